/* rtl/psq_regs.svh */
// register offsets, vectors and widths for the program sequencer
`ifndef PSQ_REGS_SVH
`define PSQ_REGS_SVH
`define PSQ_OFF_PC_LOW 8'h06
`define PSQ_OFF_TBL_PTR 8'h07
`define PSQ_OFF_TBL_HIGH 8'h08
`define PSQ_VEC_RESET 13'h0000
`define PSQ_VEC_EXT 13'h0004
`define PSQ_VEC_TMR0 13'h0008
`define PSQ_VEC_TMR1 13'h000c
`define PSQ_BANK_RESET 3'h0
`define PSQ_OSC_DIV 2
`define PSQ_PHASES 4
`define PSQ_LAST_PAGE 8'hff
`define PSQ_WAVE_LOW 5'h00
`define PSQ_STACK_DEPTH 8
`endif

/* rtl/psq_pkg.sv */
// types shared by the program sequencer files
package psq_pkg;
    typedef enum logic [2:0] {
        PSQ_OP_NEXT, PSQ_OP_SKIP, PSQ_OP_JUMP, PSQ_OP_CALL,
        PSQ_OP_RET, PSQ_OP_TBL_CUR, PSQ_OP_TBL_LAST, PSQ_OP_BANK_WR
    } psq_op_t;
    typedef enum logic [1:0] {PSQ_PH0, PSQ_PH1, PSQ_PH2, PSQ_PH3} psq_phase_t;
endpackage

/* rtl/psq_phase_gen.sv */
// oscillator halving and four-phase instruction cycle generator
`timescale 1ns/1ps
`include "psq_regs.svh"
module psq_phase_gen #(
    parameter int OSC_DIV = `PSQ_OSC_DIV
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    output logic sys_en_o,
    output logic [3:0] phase_o,
    output logic cycle_end_o
);
    import psq_pkg::*;
    typedef struct packed {
        logic div;
        psq_phase_t ph;
    } psq_pg_state_t;
    psq_pg_state_t s_q, s_d;
    initial begin
        if (OSC_DIV != 2) $error("only oscillator halving supported");
    end
    // ----------------------------------------
    // phase stepping
    // ----------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.div = ~s_q.div; // oscillator over two [RULE_01]
        if (s_q.div) begin
            s_d.ph = psq_phase_t'(s_q.ph + 2'h1); // four system clocks [RULE_02]
        end
    end
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    // one-hot non-overlapping phases, only high while enable is present [RULE_01]
    assign sys_en_o = s_q.div;
    assign phase_o = s_q.div ? (4'h1 << s_q.ph) : 4'h0;
    assign cycle_end_o = s_q.div && (s_q.ph == PSQ_PH3); // [RULE_02]
endmodule

/* rtl/psq_stack.sv */
// eight-entry return address stack with full flag
`timescale 1ns/1ps
`include "psq_regs.svh"
module psq_stack #(
    parameter int DEPTH = `PSQ_STACK_DEPTH,
    parameter int AW = 16
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic push_i,
    input wire logic pop_i,
    input wire logic [AW-1:0] push_addr_i,
    output logic [AW-1:0] top_o,
    output logic full_o
);
    localparam int PW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][AW-1:0] mem;
        logic [PW-1:0] ptr;
        logic [PW:0] cnt;
    } psq_stk_state_t;
    psq_stk_state_t s_q, s_d;
    initial begin
        if (DEPTH < 2 || (1 << PW) != DEPTH) $error("stack depth must be a power of two");
    end
    // ----------------------------------------
    // push wraps, overwriting the oldest entry
    // ----------------------------------------
    always_comb begin
        s_d = s_q;
        if (push_i) begin
            s_d.mem[s_q.ptr] = push_addr_i; // [RULE_22]
            s_d.ptr = s_q.ptr + 1'b1;
            if (s_q.cnt != DEPTH[PW:0]) s_d.cnt = s_q.cnt + 1'b1;
        end else if (pop_i && s_q.cnt != '0) begin
            s_d.ptr = s_q.ptr - 1'b1; // [RULE_13]
            s_d.cnt = s_q.cnt - 1'b1;
        end
    end
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign top_o = s_q.mem[s_q.ptr - 1'b1];
    assign full_o = (s_q.cnt == DEPTH[PW:0]);
endmodule

/* rtl/psq_sequencer.sv */
// program sequencer: pc, banks, interrupts, table and wavetable addressing
//
// Behaviour
// [RULE_01] system clock is oscillator halved, four phases
// [RULE_02] instruction cycle is four system clocks
// [RULE_03] fetch overlaps; pc change adds dummy
// [RULE_04] program counter is thirteen bits wide
// [RULE_05] pc increments after every fetch
// [RULE_06] true skip discards fetched word
// [RULE_07] pc low byte at 06h, page jump
// [RULE_08] reset starts at word zero bank zero
// [RULE_09] external interrupt vectors to 004h
// [RULE_10] timer 0 overflow vectors to 008h
// [RULE_11] timer 1 overflow vectors to 00ch
// [RULE_12] jump and call load immediate thirteen bits
// [RULE_13] return restores address from stack top
// [RULE_14] fetch address is bank over pc
// [RULE_15] current page table read, high latch
// [RULE_16] last page table read forces ones
// [RULE_17] table pointer rw 07h, latch read only
// [RULE_18] table reads take two cycles
// [RULE_19] eight banks, write delayed one instruction
// [RULE_20] wavetable start field maps to bits 16..5
// [RULE_21] samples aligned to 32 bytes by software
// [RULE_22] eight level stack, pushed on call/interrupt
// [RULE_23] stack full holds interrupt pending
// [RULE_24] external beats timer 0 beats timer 1
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps
`include "psq_regs.svh"
module psq_sequencer #(
    parameter int PC_W = 13,
    parameter int BANK_W = 3,
    parameter int ST_W = 12
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // decoded instruction from the execute stage
    input wire logic op_valid_i,
    input psq_pkg::psq_op_t op_i,
    input wire logic [PC_W-1:0] op_target_i,
    input wire logic [BANK_W-1:0] op_bank_i,
    input wire logic skip_cond_i,
    // interrupt sources
    input wire logic ext_int_n_i,
    input wire logic ext_int_en_i,
    input wire logic tmr0_ovf_i,
    input wire logic tmr0_en_i,
    input wire logic tmr1_ovf_i,
    input wire logic tmr1_en_i,
    // register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // program and wavetable rom
    output logic [15:0] rom_addr_o,
    input wire logic [15:0] rom_data_i,
    input wire logic [ST_W-1:0] sample_start_field_i,
    output logic [16:0] wave_addr_o,
    // status to the core
    output logic [3:0] phase_o,
    output logic cycle_end_o,
    output logic [15:0] instr_o,
    output logic instr_valid_o,
    output logic [7:0] tbl_low_o,
    output logic tbl_low_valid_o,
    output logic [2:0] int_ack_o,
    output logic [2:0] int_pend_o,
    output logic stack_full_o
);
    import psq_pkg::*;
    typedef struct packed {
        logic [PC_W-1:0] pc;
        logic [BANK_W-1:0] bank;
        logic [BANK_W-1:0] bank_pend;
        logic bank_wait;
        logic [1:0] bank_cnt;
        logic dummy;
        logic tbl_busy;
        logic tbl_last;
        logic [7:0] tbl_ptr;
        logic [7:0] tbl_high;
        logic [7:0] tbl_low;
        logic tbl_low_v;
        logic [15:0] instr;
        logic instr_v;
        logic [2:0] pend;
        logic [2:0] ack;
        logic ext_s1;
        logic ext_s2;
        logic [7:0] rdata;
        logic [16:0] wave;
    } psq_seq_state_t;
    psq_seq_state_t s_q, s_d;
    logic cyc_end;
    logic [15:0] stk_top;
    logic stk_full;
    logic stk_push;
    logic stk_pop;
    logic [15:0] push_addr;

    initial begin
        if (PC_W != 13 || BANK_W != 3 || ST_W != 12) $error("widths fixed by rom map");
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // program fetch address, bank over pc
    function automatic logic [15:0] fetch_addr(input logic [BANK_W-1:0] b,
                                               input logic [PC_W-1:0] p);
        fetch_addr = {b, p}; // [RULE_14]
    endfunction
    // table address, current or last page
    function automatic logic [15:0] tbl_addr(input logic last, input logic [BANK_W-1:0] b,
                                             input logic [PC_W-1:0] p, input logic [7:0] t);
        if (last) begin
            tbl_addr = {`PSQ_LAST_PAGE, t}; // [RULE_16]
        end else begin
            tbl_addr = {b, p[PC_W-1:8], t}; // [RULE_15]
        end
    endfunction

    // ----------------------------------------
    // sub blocks
    // ----------------------------------------
    psq_phase_gen #(
        .OSC_DIV(`PSQ_OSC_DIV)
    ) u_phase (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .sys_en_o(), // phases already carry the enable
        .phase_o(phase_o),
        .cycle_end_o(cyc_end)
    );
    psq_stack #(
        .DEPTH(`PSQ_STACK_DEPTH),
        .AW(16)
    ) u_stack (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .push_i(stk_push),
        .pop_i(stk_pop),
        .push_addr_i(push_addr),
        .top_o(stk_top),
        .full_o(stk_full)
    );

    // stack control, only at instruction boundaries, on live ops or taken interrupts
    logic live_op;
    logic int_take;
    assign live_op = cyc_end && op_valid_i && !s_q.dummy && !s_q.tbl_busy;
    assign int_take = cyc_end && !s_q.dummy && !s_q.tbl_busy && (s_q.pend != 3'h0)
                      && !stk_full && !(live_op && op_i inside {PSQ_OP_CALL, PSQ_OP_RET}); // [RULE_23]
    assign stk_push = (live_op && op_i == PSQ_OP_CALL) || int_take; // [RULE_22]
    assign stk_pop = live_op && op_i == PSQ_OP_RET && !int_take; // [RULE_13]
    assign push_addr = fetch_addr(s_q.bank, s_q.pc);

    // ----------------------------------------
    // sequencing
    // ----------------------------------------
    // interrupt requests latched each clock, set wins over acknowledge
    always_comb begin
        logic [2:0] req;
        logic [2:0] grant;
        req = '0;
        grant = '0;
        s_d = s_q;
        s_d.ext_s1 = ext_int_n_i;
        s_d.ext_s2 = s_q.ext_s1; // pin input passes two flops
        s_d.instr_v = 1'b0;
        s_d.tbl_low_v = 1'b0;
        s_d.ack = 3'h0;
        req[0] = !s_q.ext_s2 && ext_int_en_i;
        req[1] = tmr0_ovf_i && tmr0_en_i;
        req[2] = tmr1_ovf_i && tmr1_en_i;
        // fixed priority, one grant per boundary
        if (int_take) begin
            if (s_q.pend[0]) grant = 3'h1; // [RULE_24]
            else if (s_q.pend[1]) grant = 3'h2;
            else grant = 3'h4;
        end
        s_d.pend = (s_q.pend & ~grant) | req; // held while stack full [RULE_23]
        s_d.ack = grant;

        // register writes; software owns table pointer [RULE_17]
        if (reg_wr_i && reg_addr_i == `PSQ_OFF_TBL_PTR) s_d.tbl_ptr = reg_wdata_i; // [RULE_17]

        if (cyc_end) begin
            s_d.dummy = 1'b0;
            // pending bank change lands after the next full instruction
            if (s_q.bank_wait) begin
                if (s_q.bank_cnt == 2'h1) begin
                    s_d.bank = s_q.bank_pend; // [RULE_19]
                    s_d.bank_wait = 1'b0;
                end
                s_d.bank_cnt = s_q.bank_cnt + 2'h1;
            end
            if (s_q.tbl_busy) begin
                // second table cycle: capture both halves [RULE_18]
                s_d.tbl_busy = 1'b0;
                s_d.tbl_high = rom_data_i[15:8]; // [RULE_15]
                s_d.tbl_low = rom_data_i[7:0];
                s_d.tbl_low_v = 1'b1;
            end else if (s_q.dummy) begin
                s_d.pc = s_q.pc + 1'b1; // refetch after a transfer [RULE_03]
                s_d.instr = rom_data_i;
                s_d.instr_v = 1'b1;
            end else begin
                s_d.pc = s_q.pc + 1'b1; // [RULE_05]
                s_d.instr = rom_data_i;
                s_d.instr_v = 1'b1;
                if (int_take) begin
                    s_d.pc = grant[0] ? `PSQ_VEC_EXT : (grant[1] ? `PSQ_VEC_TMR0
                                                                  : `PSQ_VEC_TMR1); // [RULE_09]
                    s_d.dummy = 1'b1; // vector within bank [RULE_10] [RULE_11]
                    s_d.instr_v = 1'b0;
                end else if (live_op) begin
                    case (op_i)
                        PSQ_OP_SKIP: begin
                            if (skip_cond_i) begin
                                s_d.dummy = 1'b1; // [RULE_06]
                                s_d.instr_v = 1'b0;
                            end
                        end
                        PSQ_OP_JUMP, PSQ_OP_CALL: begin
                            s_d.pc = op_target_i; // [RULE_12]
                            s_d.dummy = 1'b1; // [RULE_03]
                            s_d.instr_v = 1'b0;
                        end
                        PSQ_OP_RET: begin
                            s_d.pc = stk_top[PC_W-1:0]; // [RULE_13]
                            s_d.bank = stk_top[15:PC_W];
                            s_d.dummy = 1'b1;
                            s_d.instr_v = 1'b0;
                        end
                        PSQ_OP_TBL_CUR, PSQ_OP_TBL_LAST: begin
                            s_d.tbl_busy = 1'b1; // [RULE_18]
                            s_d.tbl_last = (op_i == PSQ_OP_TBL_LAST);
                            s_d.pc = s_q.pc;
                            s_d.instr_v = 1'b0;
                        end
                        PSQ_OP_BANK_WR: begin
                            s_d.bank_pend = op_bank_i; // [RULE_19]
                            s_d.bank_wait = 1'b1;
                            s_d.bank_cnt = 2'h0;
                        end
                        default: begin
                        end
                    endcase
                end
            end
        end
        // pc low write: page jump with dummy, wins over increment [RULE_07]
        if (reg_wr_i && reg_addr_i == `PSQ_OFF_PC_LOW) begin
            s_d.pc = {s_q.pc[PC_W-1:8], reg_wdata_i}; // [RULE_07]
            s_d.dummy = 1'b1;
            s_d.instr_v = 1'b0;
        end
        // read data one cycle later, unmapped reads zero
        s_d.rdata = 8'h00;
        if (reg_rd_i) begin
            case (reg_addr_i)
                `PSQ_OFF_PC_LOW: s_d.rdata = s_q.pc[7:0]; // [RULE_07]
                `PSQ_OFF_TBL_PTR: s_d.rdata = s_q.tbl_ptr; // [RULE_17]
                `PSQ_OFF_TBL_HIGH: s_d.rdata = s_q.tbl_high; // read only [RULE_17]
                default: s_d.rdata = 8'h00;
            endcase
        end
        // wavetable start mapping, aligned by software [RULE_20] [RULE_21]
        s_d.wave = {sample_start_field_i, `PSQ_WAVE_LOW};
    end

    // reset clears pc and bank [RULE_08]
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_q <= '0;
            s_q.pc <= `PSQ_VEC_RESET; // [RULE_08]
            s_q.bank <= `PSQ_BANK_RESET;
            s_q.ext_s1 <= 1'b1;
            s_q.ext_s2 <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    // rom address is table address only during the second table cycle
    assign rom_addr_o = s_q.tbl_busy ? tbl_addr(s_q.tbl_last, s_q.bank, s_q.pc, s_q.tbl_ptr)
                                     : fetch_addr(s_q.bank, s_q.pc); // [RULE_14]
    assign wave_addr_o = s_q.wave;
    assign reg_rdata_o = s_q.rdata;
    assign cycle_end_o = cyc_end;
    assign instr_o = s_q.instr;
    assign instr_valid_o = s_q.instr_v;
    assign tbl_low_o = s_q.tbl_low;
    assign tbl_low_valid_o = s_q.tbl_low_v;
    assign int_ack_o = s_q.ack;
    assign int_pend_o = s_q.pend;
    assign stack_full_o = stk_full;
endmodule

/* verification/psq_rom_model.sv */
// program and wavetable rom model answering every word address at once
`timescale 1ns/1ps
module psq_rom_model (
    input wire logic [15:0] addr_i,
    output logic [15:0] data_o
);
    // ---------------------------------------------------------------
    // word pattern
    // ---------------------------------------------------------------
    // high byte from the low address half, low byte from the high half, so swapped fields show up
    assign data_o = {addr_i[7:0] ^ 8'h3c, addr_i[15:8] ^ 8'ha5};
endmodule

/* verification/psq_sequencer_chk.sv */
// port checker for the program sequencer
`timescale 1ns/1ps
module psq_sequencer_chk #(
    parameter int ST_W = 12
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic [15:0] rom_addr_o,
    input wire logic [ST_W-1:0] sample_start_field_i,
    input wire logic [16:0] wave_addr_o,
    input wire logic [3:0] phase_o,
    input wire logic cycle_end_o,
    input wire logic instr_valid_o,
    input wire logic [2:0] int_ack_o,
    input wire logic [2:0] int_pend_o,
    input wire logic stack_full_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);
    // ---------------------------------------------------------------
    // sequences
    // ---------------------------------------------------------------
    sequence s_phases;
        ##2 phase_o[1] ##2 phase_o[2] ##2 (phase_o[3] && cycle_end_o);
    endsequence
    sequence s_gap;
        !cycle_end_o [*7] ##1 cycle_end_o;
    endsequence
    // vector must show within two instruction cycles of the ack
    sequence s_vec(logic [12:0] v);
        ##[0:16] (rom_addr_o[12:0] == v);
    endsequence
    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    a_phase_onehot: assert property ($onehot0(phase_o))
        else $error("phase not one-hot");
    a_phase_gap: assert property (|phase_o |=> phase_o == 4'h0)
        else $error("phase on two clocks running");
    a_phase_walk: assert property (phase_o[0] |-> s_phases)
        else $error("phase walk broken");
    a_cycle_len: assert property (cycle_end_o |=> s_gap)
        else $error("instruction cycle not eight clocks");
    a_fetch_edge: assert property (instr_valid_o |-> $past(cycle_end_o))
        else $error("fetch off the boundary");
    a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
        else $error("read data outside its cycle");
    a_wave_map: assert property (!$past(rst_i) |->
        wave_addr_o == {$past(sample_start_field_i), 5'h00})
        else $error("wave address mapping wrong");
    a_ext_vec: assert property (int_ack_o[0] |-> s_vec(13'h004))
        else $error("external vector wrong");
    a_tmr0_vec: assert property (int_ack_o[1] |-> s_vec(13'h008))
        else $error("timer 0 vector wrong");
    a_tmr1_vec: assert property (int_ack_o[2] |-> s_vec(13'h00c))
        else $error("timer 1 vector wrong");
    a_ack_single: assert property ($onehot0(int_ack_o))
        else $error("two acks at once");
    a_full_noack: assert property (stack_full_o && $past(stack_full_o) |-> int_ack_o == 3'h0)
        else $error("ack while stack full");
    a_pend_hold: assert property (int_pend_o[1] && !int_ack_o[1] |=> int_pend_o[1] || int_ack_o[1])
        else $error("pending lost without ack");
endmodule
bind psq_sequencer psq_sequencer_chk #(.ST_W(ST_W)) u_chk (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .rom_addr_o(rom_addr_o),
    .sample_start_field_i(sample_start_field_i), .wave_addr_o(wave_addr_o), .phase_o(phase_o),
    .cycle_end_o(cycle_end_o), .instr_valid_o(instr_valid_o), .int_ack_o(int_ack_o),
    .int_pend_o(int_pend_o), .stack_full_o(stack_full_o));

/* verification/psq_sequencer_tb.sv */
// self-checking testbench for the program sequencer
`timescale 1ns/1ps
module psq_sequencer_tb;
    import psq_pkg::*;
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic op_valid_i = 1'b0;
    psq_op_t op_i = PSQ_OP_NEXT;
    logic [12:0] op_target_i = 13'h0000;
    logic [2:0] op_bank_i = 3'h0;
    logic skip_cond_i = 1'b0, ext_int_n_i = 1'b1, ext_int_en_i = 1'b0;
    logic tmr0_ovf_i = 1'b0, tmr0_en_i = 1'b0, tmr1_ovf_i = 1'b0, tmr1_en_i = 1'b0;
    logic reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o, tbl_low_o;
    logic [11:0] sample_start_field_i = 12'h000;
    logic [15:0] rom_addr_o, rom_data_i, instr_o;
    logic [16:0] wave_addr_o;
    logic [3:0] phase_o;
    logic [2:0] int_ack_o, int_pend_o;
    logic cycle_end_o, instr_valid_o, tbl_low_valid_o, stack_full_o;
    int fails = 0, n_checks = 0, cycles = 0;
    // ---------------------------------------------------------------
    // design, rom and clock
    // ---------------------------------------------------------------
    psq_sequencer dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .op_valid_i(op_valid_i),
        .op_i(op_i), .op_target_i(op_target_i), .op_bank_i(op_bank_i),
        .skip_cond_i(skip_cond_i), .ext_int_n_i(ext_int_n_i), .ext_int_en_i(ext_int_en_i),
        .tmr0_ovf_i(tmr0_ovf_i), .tmr0_en_i(tmr0_en_i), .tmr1_ovf_i(tmr1_ovf_i),
        .tmr1_en_i(tmr1_en_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .rom_addr_o(rom_addr_o), .rom_data_i(rom_data_i),
        .sample_start_field_i(sample_start_field_i), .wave_addr_o(wave_addr_o),
        .phase_o(phase_o), .cycle_end_o(cycle_end_o), .instr_o(instr_o),
        .instr_valid_o(instr_valid_o), .tbl_low_o(tbl_low_o), .tbl_low_valid_o(tbl_low_valid_o),
        .int_ack_o(int_ack_o), .int_pend_o(int_pend_o), .stack_full_o(stack_full_o));
    psq_rom_model u_rom (.addr_i(rom_addr_o), .data_o(rom_data_i));
    always #5 sys_clk_i = ~sys_clk_i;
    // ---------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------
    function automatic logic [15:0] rom(input logic [15:0] a);
        return {a[7:0] ^ 8'h3c, a[15:8] ^ 8'ha5};
    endfunction
    task automatic check(input logic [16:0] seen, input logic [16:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        if (fails == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b0;
        @(negedge sys_clk_i);
        d = reg_rdata_o;
    endtask
    // op held through the next boundary, taken or not; returns just after that boundary
    task automatic step(input psq_op_t op, input logic [12:0] tgt, input logic cond);
        @(posedge sys_clk_i);
        op_valid_i <= 1'b1;
        op_i <= op;
        op_target_i <= tgt;
        op_bank_i <= tgt[2:0];
        skip_cond_i <= cond;
        @(negedge sys_clk_i);
        for (int i = 0; i < 9 && cycle_end_o !== 1'b1; i++) @(negedge sys_clk_i);
        @(posedge sys_clk_i);
        op_valid_i <= 1'b0;
        @(negedge sys_clk_i);
    endtask
    task automatic wait_ack(input int idx);
        @(negedge sys_clk_i);
        for (int i = 0; i < 40 && int_ack_o === 3'h0; i++) @(negedge sys_clk_i);
        check(17'(int_ack_o), 17'(1 << idx));
    endtask
    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_flow();
        logic [15:0] a;
        step(PSQ_OP_NEXT, 13'h0, 1'b0);
        check(17'(rom_addr_o), 17'h1);
        check(17'(instr_o), 17'(rom(16'h0)));
        step(PSQ_OP_JUMP, 13'h1234, 1'b0);
        check(17'(rom_addr_o), 17'h1234);
        step(PSQ_OP_JUMP, 13'h0abc, 1'b0);
        check(17'(rom_addr_o), 17'h1235);
        check(17'(instr_o), 17'(rom(16'h1234)));
        step(PSQ_OP_SKIP, 13'h0, 1'b1);
        check(17'(instr_valid_o), 17'h0);
        step(PSQ_OP_NEXT, 13'h0, 1'b0);
        check(17'(rom_addr_o), 17'h1237);
        check(17'(instr_o), 17'(rom(16'h1236)));
        step(PSQ_OP_SKIP, 13'h0, 1'b0);
        check(17'(instr_valid_o), 17'h1);
        a = rom_addr_o;
        step(PSQ_OP_CALL, 13'h1fff, 1'b0);
        step(PSQ_OP_NEXT, 13'h0, 1'b0);
        check(17'(rom_addr_o), 17'h0);
        step(PSQ_OP_RET, 13'h0, 1'b0);
        check(17'(rom_addr_o), 17'(a));
    endtask
    task automatic t_regs();
        logic [7:0] d;
        logic [15:0] p;
        wr(8'h07, 8'h37);
        rd(8'h07, d);
        check(17'(d), 17'h37);
        rd(8'h40, d);
        check(17'(d), 17'h0);
        @(posedge sys_clk_i);
        sample_start_field_i <= 12'habc; // sample kept on a 32-byte boundary
        repeat (2) @(negedge sys_clk_i);
        check(wave_addr_o, 17'h15780);
        step(PSQ_OP_NEXT, 13'h0, 1'b0);
        p = rom_addr_o;
        wr(8'h06, 8'h5a);
        @(negedge sys_clk_i);
        check(17'(rom_addr_o), 17'({p[15:8], 8'h5a}));
        rd(8'h06, d);
        check(17'(d), 17'h5a);
    endtask
    task automatic t_table();
        logic [15:0] p;
        logic [15:0] e;
        logic [7:0] d;
        for (int i = 0; i < 2; i++) begin
            step(PSQ_OP_NEXT, 13'h0, 1'b0);
            p = rom_addr_o;
            e = (i == 1) ? 16'hff37 : {p[15:8], 8'h37};
            step((i == 1) ? PSQ_OP_TBL_LAST : PSQ_OP_TBL_CUR, 13'h0, 1'b0);
            check(17'(rom_addr_o), 17'(e));
            step(PSQ_OP_NEXT, 13'h0, 1'b0);
            check(17'(tbl_low_valid_o), 17'h1);
            check(17'(tbl_low_o), 17'(rom(e) & 16'h00ff));
            wr(8'h08, 8'h00);
            rd(8'h08, d);
            check(17'({d, 8'h00}), 17'(rom(e) & 16'hff00));
        end
    endtask
    task automatic t_bank_int();
        step(PSQ_OP_BANK_WR, 13'h0003, 1'b0);
        step(PSQ_OP_NEXT, 13'h0, 1'b0);
        check(17'(rom_addr_o[15:13]), 17'h0);
        step(PSQ_OP_NEXT, 13'h0, 1'b0);
        check(17'(rom_addr_o[15:13]), 17'h3);
        // all three sources raised inside one instruction cycle
        @(posedge sys_clk_i);
        {ext_int_n_i, ext_int_en_i, tmr0_en_i, tmr1_en_i} <= 4'b0111;
        {tmr0_ovf_i, tmr1_ovf_i} <= 2'b11;
        @(posedge sys_clk_i);
        {tmr0_ovf_i, tmr1_ovf_i} <= 2'b00;
        repeat (3) @(posedge sys_clk_i);
        ext_int_n_i <= 1'b1;
        wait_ack(0);
        wait_ack(1);
        wait_ack(2);
        repeat (2) step(PSQ_OP_NEXT, 13'h0, 1'b0);
        for (int i = 0; i < 5; i++) begin
            step(PSQ_OP_CALL, 13'h0100, 1'b0);
            check(17'(stack_full_o), 17'(i == 4));
            step(PSQ_OP_NEXT, 13'h0, 1'b0);
        end
        @(posedge sys_clk_i);
        tmr0_ovf_i <= 1'b1;
        @(posedge sys_clk_i);
        tmr0_ovf_i <= 1'b0;
        repeat (2) step(PSQ_OP_NEXT, 13'h0, 1'b0);
        check(17'(int_pend_o), 17'h2);
        step(PSQ_OP_RET, 13'h0, 1'b0);
        wait_ack(1);
    endtask
    // ---------------------------------------------------------------
    // main sequence and hang guard
    // ---------------------------------------------------------------
    initial begin
        repeat (12) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        @(negedge sys_clk_i);
        check(17'(rom_addr_o), 17'h0);
        t_flow();
        t_regs();
        t_table();
        t_bank_int();
        end_of_test();
    end
    // run needs about four hundred clocks; ten times that means a hang
    always @(posedge sys_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            fails++;
            end_of_test();
        end
    end
endmodule
